// File: rtl/tolc_top.sv
// Purpose: Timer counter with buffered reload gated by a load-ok bit
// Assumes: Software strobes come from logic on the system clock
// Notes: Registers are plain ports; no bus slave
`timescale 1ns/10ps
`default_nettype none
`include "tolc_regs.svh"

// What this block does
// - Writes to the load register with byte lane 1 disabled leave load-ok untouched.
// - Buffered modulo, initial count and channel value load only while load-ok set.
// - Flag clears after a status read followed by writing zero to it.
// - Interrupt request stays asserted while flag set and enable is one.
// - Overflows are counted against a nonzero count field to set the flag.
// - Counter reaching modulo is an overflow event feeding count and flag.
module tolc_top
  import tolc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CNT_EN,
  input wire logic I_LOAD_WR,
  input wire logic [`TOLC_BE_W-1:0] I_LOAD_BE,
  input wire logic [`TOLC_LOAD_W-1:0] I_LOAD_WDATA,
  input wire logic I_MOD_WR,
  input wire logic [`TOLC_CNT_W-1:0] I_MOD_WDATA,
  input wire logic I_CNTIN_WR,
  input wire logic [`TOLC_CNT_W-1:0] I_CNTIN_WDATA,
  input wire logic I_CV_WR,
  input wire logic [`TOLC_CNT_W-1:0] I_CV_WDATA,
  input wire logic I_SC_RD,
  input wire logic I_SC_WR,
  input wire logic I_SC_WR_TOF,
  input wire logic I_OVERFLOW_IRQ_ENABLE,
  input wire logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] I_OVERFLOW_COUNT_FIELD,
  output logic [`TOLC_LOAD_W-1:0] O_LOAD,
  output logic O_LOAD_OK,
  output logic [`TOLC_CNT_W-1:0] O_CNT,
  output logic [`TOLC_CNT_W-1:0] O_MOD,
  output logic [`TOLC_CNT_W-1:0] O_CNTIN,
  output logic [`TOLC_CNT_W-1:0] O_CV,
  output logic O_PWM,
  output logic O_OVF,
  output logic O_TOF,
  output logic O_IRQ,
  output logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] O_TOF_CNT
);

  tolc_cnt_st_t st_reg;
  tolc_cnt_st_t st_next;
  tolc_ovf_if ovf_bus ();
  logic ovf_evt;

  // ----------------------------------------------------------------
  // Overflow detection
  // ----------------------------------------------------------------
  // Counter at modulo while running is one overflow event
  assign ovf_evt = I_CNT_EN && (st_reg.cnt == st_reg.mod_act);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Buffer writes, counting, gated reload and load register lanes
  always_comb begin
    st_next = st_reg;
    if (I_MOD_WR) begin
      st_next.mod_buf = I_MOD_WDATA;
    end
    if (I_CNTIN_WR) begin
      st_next.cntin_buf = I_CNTIN_WDATA;
    end
    if (I_CV_WR) begin
      st_next.cv_buf = I_CV_WDATA;
    end
    if (ovf_evt) begin
      st_next.cnt = st_reg.cntin_act;
      // Reload takes effect at the wrap, only with load-ok set
      if (st_reg.load[`TOLC_LOAD_OK_BIT_BIT]) begin
        st_next.mod_act = st_reg.mod_buf;
        st_next.cntin_act = st_reg.cntin_buf;
        st_next.cv_act = st_reg.cv_buf;
        st_next.cnt = st_reg.cntin_buf;
        st_next.load[`TOLC_LOAD_OK_BIT_BIT] = 1'b0;
      end
    end else if (I_CNT_EN) begin
      st_next.cnt = st_reg.cnt + `TOLC_CNT_W'(1);
    end
    // Only enabled byte lanes change; other lanes keep load-ok as is
    if (I_LOAD_WR) begin
      for (int b = 0; b < `TOLC_BE_W; b++) begin
        if (I_LOAD_BE[b]) begin
          st_next.load[b*8 +: 8] = I_LOAD_WDATA[b*8 +: 8];
        end
      end
    end
    st_next.pwm = (st_next.cnt < st_next.cv_act);
  end

  // State register
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_reg.cnt <= `TOLC_CNTIN_RST;
      st_reg.mod_buf <= `TOLC_MOD_RST;
      st_reg.cntin_buf <= `TOLC_CNTIN_RST;
      st_reg.cv_buf <= `TOLC_CV_RST;
      st_reg.mod_act <= `TOLC_MOD_RST;
      st_reg.cntin_act <= `TOLC_CNTIN_RST;
      st_reg.cv_act <= `TOLC_CV_RST;
      st_reg.load <= `TOLC_LOAD_RST;
      st_reg.pwm <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag logic
  // ----------------------------------------------------------------
  // Software strobes and configuration pass straight to the flag logic
  assign ovf_bus.ovf_evt = ovf_evt;
  assign ovf_bus.sc_rd = I_SC_RD;
  assign ovf_bus.sc_wr = I_SC_WR;
  assign ovf_bus.sc_wr_tof = I_SC_WR_TOF;
  assign ovf_bus.overflow_irq_enable = I_OVERFLOW_IRQ_ENABLE;
  assign ovf_bus.overflow_count_field = I_OVERFLOW_COUNT_FIELD;

  tolc_ovf u_ovf (
    .i_clk(I_SYS_CLK),
    .i_arst_n(I_ARST_N),
    .bus(ovf_bus.flag)
  );

  // Outputs
  assign O_LOAD = st_reg.load;
  assign O_LOAD_OK = st_reg.load[`TOLC_LOAD_OK_BIT_BIT];
  assign O_CNT = st_reg.cnt;
  assign O_MOD = st_reg.mod_act;
  assign O_CNTIN = st_reg.cntin_act;
  assign O_CV = st_reg.cv_act;
  assign O_PWM = st_reg.pwm;
  assign O_OVF = ovf_evt;
  assign O_TOF = ovf_bus.overflow_flag;
  assign O_IRQ = ovf_bus.irq;
  assign O_TOF_CNT = ovf_bus.tof_cnt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence s_narrow_write;
    I_LOAD_WR && !I_LOAD_BE[1] && !ovf_evt;
  endsequence

  a_load_ok_bit_narrow_keep: assert property (s_narrow_write |=> O_LOAD_OK == $past(O_LOAD_OK))
    else $error("load-ok changed by write without its byte lane");
  a_load_gated: assert property (ovf_evt && !O_LOAD_OK |=> O_MOD == $past(O_MOD))
    else $error("modulo reloaded with load-ok clear");
  a_load_taken: assert property (ovf_evt && O_LOAD_OK |=> O_MOD == $past(st_reg.mod_buf)
      && O_CV == $past(st_reg.cv_buf))
    else $error("buffered values not taken with load-ok set");
  a_cnt_wrap: assert property (ovf_evt && !O_LOAD_OK |=> O_CNT == $past(O_CNTIN))
    else $error("counter did not restart after modulo");
  a_ovf_to_irq: assert property (ovf_evt && I_OVERFLOW_COUNT_FIELD == 5'h00 && I_OVERFLOW_IRQ_ENABLE ##1 I_OVERFLOW_IRQ_ENABLE |-> O_IRQ)
    else $error("interrupt missing after overflow");

endmodule : tolc_top

`default_nettype wire

// File: rtl/tolc_regs.svh
// Purpose: Constants for the timer overflow and load control block
// Assumes: 16-bit counter, one PWM channel, 100 MHz system clock
// Notes: Field positions, widths and reset values only
`ifndef TOLC_REGS_SVH
`define TOLC_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define TOLC_CNT_W 16
`define TOLC_OVERFLOW_COUNT_FIELD_W 5
`define TOLC_LOAD_W 32
`define TOLC_BE_W 4

// ----------------------------------------------------------------
// Field positions of the PWM load register
// ----------------------------------------------------------------
`define TOLC_LOAD_OK_BIT_BIT 9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TOLC_MOD_RST 16'hffff
`define TOLC_CNTIN_RST 16'h0000
`define TOLC_CV_RST 16'h0000
`define TOLC_LOAD_RST 32'h0000_0000
`define TOLC_TOFCNT_RST 5'h00

`endif

// File: rtl/tolc_pkg.sv
// Purpose: Types shared by the timer overflow and load control block
// Assumes: Constants come from tolc_regs.svh
// Notes: State of each module is one packed struct
`include "tolc_regs.svh"

package tolc_pkg;

  // ----------------------------------------------------------------
  // Counter and load state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`TOLC_CNT_W-1:0] cnt;
    logic [`TOLC_CNT_W-1:0] mod_buf;
    logic [`TOLC_CNT_W-1:0] cntin_buf;
    logic [`TOLC_CNT_W-1:0] cv_buf;
    logic [`TOLC_CNT_W-1:0] mod_act;
    logic [`TOLC_CNT_W-1:0] cntin_act;
    logic [`TOLC_CNT_W-1:0] cv_act;
    logic [`TOLC_LOAD_W-1:0] load;
    logic pwm;
  } tolc_cnt_st_t;

  // ----------------------------------------------------------------
  // Overflow flag state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic armed;
    logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] tof_cnt;
  } tolc_ovf_st_t;

endpackage : tolc_pkg

// File: rtl/tolc_ovf_if.sv
// Purpose: Carrier between the counter core and the overflow flag logic
// Assumes: One clock domain
// Notes: Core drives events and software strobes, flag logic answers
`timescale 1ns/10ps
`default_nettype none
`include "tolc_regs.svh"

interface tolc_ovf_if;
  logic ovf_evt;
  logic sc_rd;
  logic sc_wr;
  logic sc_wr_tof;
  logic overflow_irq_enable;
  logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] overflow_count_field;
  logic overflow_flag;
  logic irq;
  logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] tof_cnt;

  modport core (output ovf_evt, sc_rd, sc_wr, sc_wr_tof, overflow_irq_enable, overflow_count_field,
                input overflow_flag, irq, tof_cnt);
  modport flag (input ovf_evt, sc_rd, sc_wr, sc_wr_tof, overflow_irq_enable, overflow_count_field,
                output overflow_flag, irq, tof_cnt);
endinterface : tolc_ovf_if

`default_nettype wire

// File: rtl/tolc_ovf.sv
// Purpose: Overflow flag, occurrence count, clear sequence and interrupt
// Assumes: Strobes are one-cycle pulses on the system clock
// Notes: A new flag setting wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "tolc_regs.svh"

module tolc_ovf
  import tolc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  tolc_ovf_if.flag bus
);

  tolc_ovf_st_t st_reg;
  tolc_ovf_st_t st_next;
  logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] cnt_inc;
  logic set_tof;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Count overflows, decide flag setting, track read-then-write clear
  always_comb begin
    st_next = st_reg;
    cnt_inc = st_reg.tof_cnt + `TOLC_OVERFLOW_COUNT_FIELD_W'(1);
    set_tof = 1'b0;
    if (bus.ovf_evt) begin
      if (bus.overflow_count_field == `TOLC_OVERFLOW_COUNT_FIELD_W'(0)) begin
        set_tof = 1'b1;
      end else if (cnt_inc >= bus.overflow_count_field) begin
        set_tof = 1'b1;
        st_next.tof_cnt = `TOLC_TOFCNT_RST;
      end else begin
        st_next.tof_cnt = cnt_inc;
      end
    end
    // Reading with the flag set arms the clear; a write in any other cycle disarms
    if (bus.sc_rd && st_reg.overflow_flag) begin
      st_next.armed = 1'b1;
    end else if (bus.sc_wr) begin
      st_next.armed = 1'b0;
    end
    if (bus.sc_wr && !bus.sc_wr_tof && st_reg.armed) begin
      st_next.overflow_flag = 1'b0;
    end
    if (set_tof) begin
      st_next.overflow_flag = 1'b1; // Set wins over clear
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign bus.overflow_flag = st_reg.overflow_flag;
  assign bus.tof_cnt = st_reg.tof_cnt;
  assign bus.irq = st_reg.overflow_flag && bus.overflow_irq_enable;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_read_flag;
    bus.sc_rd && bus.overflow_flag;
  endsequence

  sequence s_write_zero;
    bus.sc_wr && !bus.sc_wr_tof && !set_tof;
  endsequence

  a_tof_clear_seq: assert property (s_read_flag ##1 s_write_zero |=> !bus.overflow_flag)
    else $error("flag not cleared after read then write zero");
  a_tof_no_unarmed: assert property (bus.overflow_flag && !st_reg.armed |=> bus.overflow_flag)
    else $error("flag cleared without prior read");
  a_tof_every_ovf: assert property (bus.ovf_evt && bus.overflow_count_field == 5'h00 |=> bus.overflow_flag)
    else $error("flag not set on overflow with count zero");
  a_tof_count_gate: assert property (
      bus.ovf_evt && bus.overflow_count_field != 5'h00 && cnt_inc < bus.overflow_count_field && !bus.overflow_flag
      && !bus.sc_rd |=> !bus.overflow_flag)
    else $error("flag set before overflow count reached");
  a_irq_follow: assert property (bus.overflow_irq_enable && bus.overflow_flag |-> bus.irq ##1 (!bus.overflow_flag || !bus.overflow_irq_enable || bus.irq))
    else $error("interrupt dropped while flag set");

endmodule : tolc_ovf

`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the timer overflow and load control block
// Assumes: Inputs change on the falling clock edge; one count-up to the reset modulo
// Notes: Later scenarios run on a short modulo so overflows come every few cycles
`timescale 1ns/10ps
`default_nettype none
`include "tolc_regs.svh"

module tb_top;
  logic sys_clk, arst_n, cnt_en, load_wr, mod_wr, cntin_wr, cv_wr;
  logic sc_rd, sc_wr, sc_wr_tof, overflow_irq_enable;
  logic [`TOLC_BE_W-1:0] load_be;
  logic [`TOLC_LOAD_W-1:0] load_wdata, load;
  logic [`TOLC_CNT_W-1:0] mod_wdata, cntin_wdata, cv_wdata, cnt, mod_act, cntin_act, cv_act;
  logic [`TOLC_OVERFLOW_COUNT_FIELD_W-1:0] overflow_count_field, tof_cnt;
  logic load_ok, pwm, ovf, overflow_flag, irq;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;

  tolc_top dut_u (.I_SYS_CLK(sys_clk), .I_ARST_N(arst_n), .I_CNT_EN(cnt_en),
    .I_LOAD_WR(load_wr), .I_LOAD_BE(load_be), .I_LOAD_WDATA(load_wdata),
    .I_MOD_WR(mod_wr), .I_MOD_WDATA(mod_wdata), .I_CNTIN_WR(cntin_wr),
    .I_CNTIN_WDATA(cntin_wdata), .I_CV_WR(cv_wr), .I_CV_WDATA(cv_wdata),
    .I_SC_RD(sc_rd), .I_SC_WR(sc_wr), .I_SC_WR_TOF(sc_wr_tof), .I_OVERFLOW_IRQ_ENABLE(overflow_irq_enable),
    .I_OVERFLOW_COUNT_FIELD(overflow_count_field), .O_LOAD(load), .O_LOAD_OK(load_ok), .O_CNT(cnt), .O_MOD(mod_act),
    .O_CNTIN(cntin_act), .O_CV(cv_act), .O_PWM(pwm), .O_OVF(ovf), .O_TOF(overflow_flag),
    .O_IRQ(irq), .O_TOF_CNT(tof_cnt));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Long enough for one full count-up plus the short scenarios
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Strobe low for a full cycle after each write so strobes never double up
  task automatic write_load(input logic [3:0] be, input logic [31:0] d);
    load_wr = 1'b1;
    load_be = be;
    load_wdata = d;
    @(negedge sys_clk);
    load_wr = 1'b0;
    @(negedge sys_clk);
  endtask : write_load

  task automatic put_bufs(input logic [15:0] m, input logic [15:0] c, input logic [15:0] v);
    mod_wr = 1'b1;
    cntin_wr = 1'b1;
    cv_wr = 1'b1;
    mod_wdata = m;
    cntin_wdata = c;
    cv_wdata = v;
    @(negedge sys_clk);
    mod_wr = 1'b0;
    cntin_wr = 1'b0;
    cv_wr = 1'b0;
    @(negedge sys_clk);
  endtask : put_bufs

  // Returns half a cycle after the rising edge that takes the overflow
  task automatic wait_ovf;
    int n;
    n = 0;
    while (ovf !== 1'b1 && n < 70000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(ovf, 1, "overflow event");
    @(negedge sys_clk);
  endtask : wait_ovf

  task automatic clear_tof;
    sc_rd = 1'b1;
    @(negedge sys_clk);
    sc_rd = 1'b0;
    sc_wr = 1'b1;
    sc_wr_tof = 1'b0;
    @(negedge sys_clk);
    sc_wr = 1'b0;
  endtask : clear_tof

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({mod_act, cnt}, {16'hffff, 16'h0000}, "reset modulo and count");
    chk({cntin_act, cv_act}, 32'h0000_0000, "reset initial and channel");
    chk(load, 32'h0000_0000, "reset load register");
    chk({load_ok, overflow_flag, irq, pwm, tof_cnt}, 32'h0000_0000, "reset flags");
  endtask : t_reset

  // Narrow writes that skip byte lane 1 must not disturb load-ok
  task automatic t_lanes;
    write_load(4'hf, 32'h0000_0200);
    chk(load_ok, 1, "load-ok after full write");
    write_load(4'h1, 32'h0000_00a5);
    chk(load, 32'h0000_02a5, "byte write");
    chk(load_ok, 1, "load-ok after byte write");
    write_load(4'hc, 32'h1234_0000);
    chk(load, 32'h1234_02a5, "halfword write");
    chk(load_ok, 1, "load-ok after halfword write");
  endtask : t_lanes

  task automatic t_reload;
    put_bufs(16'h0005, 16'h0001, 16'h0003);
    cnt_en = 1'b1;
    wait_ovf();
    chk({mod_act, cntin_act}, {16'h0005, 16'h0001}, "reload modulo and initial");
    chk(cv_act, 16'h0003, "reload channel value");
    chk({cnt, 15'h0000, pwm}, {16'h0001, 16'h0001}, "restart count and output below channel");
    chk(overflow_flag, 1, "flag on overflow");
    chk(irq, 1, "request with flag");
    @(negedge sys_clk);
    chk(load_ok, 0, "load-ok spent by reload");
    clear_tof();
  endtask : t_reload

  task automatic t_hold;
    put_bufs(16'h0007, 16'h0002, 16'h0004);
    wait_ovf();
    chk(mod_act, 16'h0005, "no reload without load-ok");
    chk(cntin_act, 16'h0001, "initial held without load-ok");
    chk(overflow_flag, 1, "flag on every overflow");
  endtask : t_hold

  task automatic t_clear;
    sc_wr = 1'b1;
    sc_wr_tof = 1'b0;
    @(negedge sys_clk);
    sc_wr = 1'b0;
    chk(overflow_flag, 1, "clear without read refused");
    clear_tof();
    chk({overflow_flag, irq}, 2'b00, "read then write zero clears");
  endtask : t_clear

  task automatic t_count;
    overflow_count_field = 5'h03;
    overflow_irq_enable = 1'b0;
    wait_ovf();
    chk({overflow_flag, tof_cnt}, {1'b0, 5'h01}, "first counted overflow");
    wait_ovf();
    chk({overflow_flag, tof_cnt}, {1'b0, 5'h02}, "second counted overflow");
    wait_ovf();
    chk({overflow_flag, tof_cnt}, {1'b1, 5'h00}, "third overflow sets flag");
    chk(irq, 0, "request masked");
  endtask : t_count

  task automatic t_reload2;
    write_load(4'hf, 32'h0000_0200);
    wait_ovf();
    chk({mod_act, cv_act}, {16'h0007, 16'h0004}, "reload after load-ok set");
    chk(cnt, 16'h0002, "count restarts at new initial");
  endtask : t_reload2

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, cnt_en, load_wr, mod_wr, cntin_wr, cv_wr, sc_rd, sc_wr, sc_wr_tof} = '0;
    overflow_irq_enable = 1'b1;
    overflow_count_field = 5'h00;
    load_be = 4'h0;
    load_wdata = 32'h0000_0000;
    {mod_wdata, cntin_wdata, cv_wdata} = '0;
    repeat (6) @(negedge sys_clk);
    t_reset();
    arst_n = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_lanes();
    t_reload();
    t_hold();
    t_clear();
    t_count();
    t_reload2();
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
